// *** ias_pkg.sv ***
// package for the integer add/subtract/multiply unit
// assumes a single 125 MHz clock domain and the plain register port of ias_top
package ias_pkg;

    // ==========================================
    // register byte offsets
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_SRC_A = 12'h004;
    localparam logic [11:0] OFS_SRC_B = 12'h008;
    localparam logic [11:0] OFS_DEST = 12'h00C;
    localparam logic [11:0] OFS_CMD = 12'h010;
    localparam logic [11:0] OFS_FLAGS = 12'h014;
    localparam logic [11:0] OFS_INT_STAT = 12'h018;
    localparam logic [11:0] OFS_INT_MASK = 12'h01C;
    localparam logic [11:0] OFS_MATH_LO = 12'h020;
    localparam logic [11:0] OFS_MATH_HI = 12'h024;
    localparam logic [11:0] OFS_ERR_CODE = 12'h028;
    localparam logic [11:0] OFS_MEM_BASE = 12'h100;
    localparam logic [11:0] OFS_MEM_LAST = 12'h1FC;

    // ==========================================
    // sizes and field positions
    localparam int MEM_WORDS = 64;
    localparam int MEM_AW = 6;
    localparam int WORD_W = 16;
    localparam int CTRL_WRAP_BIT = 0;
    localparam int OPND_CONST_BIT = 16;
    localparam int INT_TRAP_BIT = 0;
    localparam int INT_MAJOR_BIT = 1;
    localparam int INT_W = 2;

    // ==========================================
    // reset values and numeric limits
    localparam logic CTRL_WRAP_RESET = 1'b0;
    localparam logic [15:0] SAT_POS = 16'h7FFF;
    localparam logic [15:0] SAT_NEG = 16'h8000;
    localparam logic signed [31:0] LIMIT_POS = 32'sh0000_7FFF;
    localparam logic signed [31:0] LIMIT_NEG = -32'sh0000_8000;
    localparam logic [15:0] MAJOR_ERR_CODE = 16'h0020;

    // ==========================================
    // commands written to the command register
    typedef enum logic [2:0] {
        CMD_NONE = 3'b000,
        CMD_ADD = 3'b001,
        CMD_SUB = 3'b010,
        CMD_PRODUCT = 3'b011,
        CMD_END = 3'b100,
        CMD_TEMP_END = 3'b101
    } ias_cmd_t;

    typedef struct packed {
        logic sign;
        logic zero;
        logic ovf;
        logic carry;
    } ias_flags_t;

    typedef struct packed {
        logic is_const;
        logic [15:0] value;
    } ias_operand_t;

endpackage

// *** ias_top.sv ***
// integer add / subtract / multiply unit with arithmetic flags and math register
// assumes a register master on SYS_CLK that keeps the plain strobe protocol
// Notes on behaviour
// RL1: add writes A plus B; carry flag set on unsigned carry out.
// RL2: subtract writes A minus B; carry flag set on borrow.
// RL3: add and multiply set overflow when the exact result leaves 16-bit range.
// RL4: subtract sets overflow on underflow or overflow, else clears it.
// RL5: every overflow also sets the sticky overflow trap flag.
// RL6: wrap bit clear: out-of-range result saturates to 32767 or -32768.
// RL7: wrap bit set: out-of-range result keeps its truncated low 16 bits.
// RL8: wrap bit resets clear, so saturation is the default.
// RL9: wrap bit never changes math register contents.
// RL10: add, subtract, multiply set zero flag when result is zero.
// RL11: add, subtract, multiply set sign flag when result is negative.
// RL12: multiply writes A times B and always clears carry.
// RL13: multiply loads full 32-bit signed product into math register, even on overflow.
// RL14: each source is a data memory word or an immediate constant.
// RL15: program doing 32-bit add or subtract sets wrap bit and carries itself.
// RL16: program must clear the overflow trap before end of scan.
// RL17: trap still set at end or temporary end gives major error code 0020.
// RL18: math register is a low word and a high word of a 32-bit value.
// RL19: operands and results are 16-bit two's complement, overflow judged exactly.
//
// The strobed register port and the placing of the registers are this design's own decisions.
module ias_top (
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic SYS_RST,
    // register port
    input wire logic [11:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [31:0] REG_RDATA,
    // status
    output logic IRQ,
    output logic MAJOR_ERROR
);

    // ==========================================
    // registers and memory
    logic wrap_sel;
    ias_pkg::ias_operand_t src_a;
    ias_pkg::ias_operand_t src_b;
    logic [ias_pkg::MEM_AW-1:0] dest;
    ias_pkg::ias_flags_t flags;
    logic [ias_pkg::INT_W-1:0] int_stat;
    logic [ias_pkg::INT_W-1:0] int_mask;
    logic [15:0] math_lo;
    logic [15:0] math_hi;
    logic [15:0] err_code;
    logic [15:0] mem [ias_pkg::MEM_WORDS];

    // ==========================================
    // bus decode
    logic mem_hit;
    logic [ias_pkg::MEM_AW-1:0] mem_idx;
    logic cmd_wr;
    ias_pkg::ias_cmd_t cmd;

    assign mem_hit = (REG_ADDR >= ias_pkg::OFS_MEM_BASE) && (REG_ADDR <= ias_pkg::OFS_MEM_LAST);
    assign mem_idx = REG_ADDR[ias_pkg::MEM_AW+1:2];
    assign cmd_wr = REG_WR && (REG_ADDR == ias_pkg::OFS_CMD);
    assign cmd = cmd_wr ? ias_pkg::ias_cmd_t'(REG_WDATA[2:0]) : ias_pkg::CMD_NONE;

    // ==========================================
    // operand fetch and arithmetic
    logic signed [15:0] opnd_a;
    logic signed [15:0] opnd_b;
    logic signed [31:0] exact;
    logic [16:0] uns_sum;
    logic out_range;
    logic [15:0] next_dest_val;
    logic next_carry;
    logic is_arith;

    // constant or memory word per source
    assign opnd_a = src_a.is_const ? src_a.value : mem[src_a.value[ias_pkg::MEM_AW-1:0]]; // RL14
    assign opnd_b = src_b.is_const ? src_b.value : mem[src_b.value[ias_pkg::MEM_AW-1:0]]; // RL14
    assign uns_sum = {1'b0, opnd_a} + {1'b0, opnd_b};
    assign is_arith = (cmd == ias_pkg::CMD_ADD) || (cmd == ias_pkg::CMD_SUB)
        || (cmd == ias_pkg::CMD_PRODUCT);

    // exact result is 32 bits wide so no operation can lose range before the check
    always_comb begin
        case (cmd)
            ias_pkg::CMD_ADD: begin
                exact = 32'(opnd_a) + 32'(opnd_b); // RL1 RL19
                next_carry = uns_sum[16]; // RL1
            end
            ias_pkg::CMD_SUB: begin
                exact = 32'(opnd_a) - 32'(opnd_b); // RL2 RL19
                next_carry = ($unsigned(opnd_a) < $unsigned(opnd_b)); // RL2
            end
            ias_pkg::CMD_PRODUCT: begin
                exact = opnd_a * opnd_b; // RL12 RL19
                next_carry = 1'b0; // RL12
            end
            default: begin
                exact = 32'sh0000_0000;
                next_carry = 1'b0;
            end
        endcase
    end

    assign out_range = (exact > ias_pkg::LIMIT_POS) || (exact < ias_pkg::LIMIT_NEG); // RL3 RL4

    always_comb begin
        if (!out_range) begin
            next_dest_val = exact[15:0];
        end else if (wrap_sel) begin
            next_dest_val = exact[15:0]; // RL7
        end else if (exact[31]) begin
            next_dest_val = ias_pkg::SAT_NEG; // RL6
        end else begin
            next_dest_val = ias_pkg::SAT_POS; // RL6
        end
    end

    // ==========================================
    // control register
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            wrap_sel <= ias_pkg::CTRL_WRAP_RESET; // RL8
        end else if (REG_WR && REG_ADDR == ias_pkg::OFS_CTRL) begin
            wrap_sel <= REG_WDATA[ias_pkg::CTRL_WRAP_BIT];
        end
    end

    // operand and destination registers
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            src_a <= '0;
            src_b <= '0;
            dest <= '0;
        end else if (REG_WR) begin
            if (REG_ADDR == ias_pkg::OFS_SRC_A) begin
                src_a <= REG_WDATA[ias_pkg::OPND_CONST_BIT:0];
            end else if (REG_ADDR == ias_pkg::OFS_SRC_B) begin
                src_b <= REG_WDATA[ias_pkg::OPND_CONST_BIT:0];
            end else if (REG_ADDR == ias_pkg::OFS_DEST) begin
                dest <= REG_WDATA[ias_pkg::MEM_AW-1:0];
            end
        end
    end

    // ==========================================
    // data memory: bus writes and result writes never meet, one strobe per cycle
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            for (int i = 0; i < ias_pkg::MEM_WORDS; i++) begin
                mem[i] <= '0;
            end
        end else if (is_arith) begin
            mem[dest] <= next_dest_val; // RL1 RL2 RL12
        end else if (REG_WR && mem_hit) begin
            mem[mem_idx] <= REG_WDATA[15:0];
        end
    end

    // ==========================================
    // arithmetic flags, zero and sign judged on the value written to the destination
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            flags <= '0;
        end else if (is_arith) begin
            flags.carry <= next_carry; // RL1 RL2 RL12
            flags.ovf <= out_range; // RL3 RL4
            flags.zero <= (next_dest_val == 16'h0000); // RL10
            flags.sign <= next_dest_val[15]; // RL11
        end
    end

    // ==========================================
    // math register: low and high halves of the product, wrap bit not consulted
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            math_lo <= '0;
            math_hi <= '0;
        end else if (cmd == ias_pkg::CMD_PRODUCT) begin
            math_lo <= exact[15:0]; // RL13 RL18 RL9
            math_hi <= exact[31:16]; // RL13 RL18 RL9
        end
    end

    // ==========================================
    // interrupt status: set wins over a write-one clear in the same cycle
    logic [ias_pkg::INT_W-1:0] int_set;
    logic [ias_pkg::INT_W-1:0] int_clr;
    logic end_cmd;

    assign end_cmd = (cmd == ias_pkg::CMD_END) || (cmd == ias_pkg::CMD_TEMP_END);
    always_comb begin
        int_set = '0;
        int_set[ias_pkg::INT_TRAP_BIT] = is_arith && out_range; // RL5
        int_set[ias_pkg::INT_MAJOR_BIT] = end_cmd && int_stat[ias_pkg::INT_TRAP_BIT]; // RL17
    end
    assign int_clr = (REG_WR && REG_ADDR == ias_pkg::OFS_INT_STAT)
        ? REG_WDATA[ias_pkg::INT_W-1:0] : '0;

    // next status is shared so the error code can follow the major bit without lag
    logic [ias_pkg::INT_W-1:0] next_int_stat;
    assign next_int_stat = (int_stat & ~int_clr) | int_set; // RL5 RL16

    // software clears the trap before ending the scan to stay out of the fault
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            int_stat <= '0;
        end else begin
            int_stat <= next_int_stat; // RL5 RL16
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            int_mask <= '0;
        end else if (REG_WR && REG_ADDR == ias_pkg::OFS_INT_MASK) begin
            int_mask <= REG_WDATA[ias_pkg::INT_W-1:0];
        end
    end

    // error code stands while the major error flag is set
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            err_code <= '0;
        end else if (next_int_stat[ias_pkg::INT_MAJOR_BIT]) begin
            err_code <= ias_pkg::MAJOR_ERR_CODE; // RL17
        end else begin
            err_code <= '0;
        end
    end

    assign IRQ = |(int_stat & int_mask);
    assign MAJOR_ERROR = int_stat[ias_pkg::INT_MAJOR_BIT];

    // ==========================================
    // read port, data one cycle after the strobe and zero otherwise
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            REG_RDATA <= '0;
        end else if (!REG_RD) begin
            REG_RDATA <= '0;
        end else if (REG_ADDR == ias_pkg::OFS_CTRL) begin
            REG_RDATA <= {31'h0000_0000, wrap_sel};
        end else if (REG_ADDR == ias_pkg::OFS_SRC_A) begin
            REG_RDATA <= {15'h0000, src_a};
        end else if (REG_ADDR == ias_pkg::OFS_SRC_B) begin
            REG_RDATA <= {15'h0000, src_b};
        end else if (REG_ADDR == ias_pkg::OFS_DEST) begin
            REG_RDATA <= {26'h000_0000, dest};
        end else if (REG_ADDR == ias_pkg::OFS_FLAGS) begin
            REG_RDATA <= {28'h000_0000, flags};
        end else if (REG_ADDR == ias_pkg::OFS_INT_STAT) begin
            REG_RDATA <= {30'h0000_0000, int_stat};
        end else if (REG_ADDR == ias_pkg::OFS_INT_MASK) begin
            REG_RDATA <= {30'h0000_0000, int_mask};
        end else if (REG_ADDR == ias_pkg::OFS_MATH_LO) begin
            REG_RDATA <= {16'h0000, math_lo};
        end else if (REG_ADDR == ias_pkg::OFS_MATH_HI) begin
            REG_RDATA <= {16'h0000, math_hi};
        end else if (REG_ADDR == ias_pkg::OFS_ERR_CODE) begin
            REG_RDATA <= {16'h0000, err_code};
        end else if (mem_hit) begin
            REG_RDATA <= {16'h0000, mem[mem_idx]};
        end else begin
            REG_RDATA <= '0;
        end
    end

endmodule

// *** ias_asserts.sv ***
// checker for the add/subtract/multiply unit, bound to ias_top
// assumes a master that keeps the one-cycle strobe rules
module ias_asserts (
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic SYS_RST,
    // register port
    input wire logic [11:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [31:0] REG_RDATA,
    // status
    input wire logic IRQ,
    input wire logic MAJOR_ERROR
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge SYS_CLK);
    endclocking
    default disable iff (SYS_RST);
    // ====================
    // shadows, so reads are judged without seeing the datapath
    logic wrap;
    logic was_mul;
    logic cmd_wr;
    logic flag_rd;
    logic stat_wr;
    assign cmd_wr = REG_WR && REG_ADDR == ias_pkg::OFS_CMD;
    assign flag_rd = REG_RD && REG_ADDR == ias_pkg::OFS_FLAGS;
    assign stat_wr = REG_WR && REG_ADDR == ias_pkg::OFS_INT_STAT;
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            wrap <= 1'b0;
        end else if (REG_WR && REG_ADDR == ias_pkg::OFS_CTRL) begin
            wrap <= REG_WDATA[0];
        end
    end
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            was_mul <= 1'b0;
        end else if (cmd_wr && REG_WDATA[2:0] inside {3'h1, 3'h2, 3'h3}) begin
            was_mul <= REG_WDATA[2:0] == 3'h3;
        end
    end
    // ====================
    // assertions
    reset_quiet_a: assert property (disable iff (1'b0) SYS_RST |=> !IRQ && !MAJOR_ERROR)
        else $error("status high after reset");
    wrap_read_a: assert property (REG_RD && REG_ADDR == ias_pkg::OFS_CTRL
        |=> REG_RDATA == {31'h0, wrap}) else $error("wrap bit read back wrong");
    major_rise_a: assert property ($rose(MAJOR_ERROR)
        |-> $past(cmd_wr && REG_WDATA[2:1] == 2'h2)) else $error("major error without end");
    major_code_a: assert property (REG_RD && REG_ADDR == ias_pkg::OFS_ERR_CODE
        |=> REG_RDATA == (MAJOR_ERROR ? {16'h0, ias_pkg::MAJOR_ERR_CODE} : 32'h0))
        else $error("error code wrong");
    major_stay_a: assert property (MAJOR_ERROR && !stat_wr |=> MAJOR_ERROR)
        else $error("major error dropped");
    irq_hold_a: assert property (IRQ && !stat_wr && !(REG_WR && REG_ADDR == ias_pkg::OFS_INT_MASK)
        |=> IRQ) else $error("trap interrupt not sticky");
    irq_mask_a: assert property (REG_WR && REG_ADDR == ias_pkg::OFS_INT_MASK
        && REG_WDATA[1:0] == 2'h0 |=> !IRQ) else $error("masked interrupt high");
    irq_cause_a: assert property ($rose(IRQ) |-> $past(REG_WR))
        else $error("interrupt rose without a write");
    product_carry_a: assert property (flag_rd && was_mul |=> !REG_RDATA[0])
        else $error("carry set after product");
    sign_zero_a: assert property (flag_rd |=> !(REG_RDATA[2] && REG_RDATA[3]))
        else $error("zero and sign both set");
    cover property ($rose(IRQ));
    cover property ($rose(MAJOR_ERROR));
    cover property (flag_rd && was_mul);
endmodule

// *** ias_top_test.sv ***
// self-checking bench for ias_top with a behavioural reference
// assumes the ias_pkg map and read data one cycle after the strobe
module ias_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] CORNER [8] = '{16'h7FFF, 16'h8000, 16'hFFFF, 16'h0000,
        16'h0001, 16'h00B5, 16'h0100, 16'hC000};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [11:0] addr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic irq;
    logic major;
    int err_total = 0;
    int checks = 0;
    int seed = 90885;
    int cyc = 0;
    ias_top ias_top_inst (.SYS_CLK(clk), .SYS_RST(rst), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .IRQ(irq), .MAJOR_ERROR(major));
    // ====================
    // clock and hang limit
    initial begin
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_total++;
            stop_test();
        end
    end
    // ====================
    // bus and compare tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    function automatic logic [15:0] pick();
        logic [31:0] v;
        v = $random(seed);
        return v[3] ? CORNER[v[2:0]] : v[31:16];
    endfunction
    // ====================
    // main sequence
    initial begin
        logic [31:0] r, math;
        logic [15:0] a, b, dst;
        logic [5:0] ia, ib, id;
        logic [2:0] op;
        logic cy, ov, trap;
        int sa, sb, res;
        math = 32'h0;
        trap = 1'b0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rchk(ias_pkg::OFS_CTRL, 32'h0);
        for (int i = 0; i < 60; i++) begin
            a = pick();
            b = pick();
            r = $random(seed);
            ia = {1'b0, r[8:4]};
            ib = {1'b1, r[13:9]};
            id = r[19:14];
            op = r[21:20] == 2'h0 ? 3'h3 : {1'b0, r[21:20]};
            sa = $signed(a);
            sb = $signed(b);
            res = op == 3'h1 ? sa + sb : op == 3'h2 ? sa - sb : sa * sb;
            cy = op == 3'h1 ? ({1'b0, a} + {1'b0, b}) > 17'h0FFFF : op == 3'h2 && a < b;
            ov = res > 32767 || res < -32768;
            dst = ov && !r[0] ? (res > 0 ? ias_pkg::SAT_POS : ias_pkg::SAT_NEG) : res[15:0];
            trap = trap | ov;
            math = op == 3'h3 ? res : math;
            wr_reg(ias_pkg::OFS_CTRL, {31'h0, r[0]});
            wr_reg(ias_pkg::OFS_MEM_BASE + {4'h0, ia, 2'h0}, {16'h0, a});
            wr_reg(ias_pkg::OFS_MEM_BASE + {4'h0, ib, 2'h0}, {16'h0, b});
            wr_reg(ias_pkg::OFS_SRC_A, {15'h0, r[1], r[1] ? a : {10'h0, ia}});
            wr_reg(ias_pkg::OFS_SRC_B, {15'h0, r[2], r[2] ? b : {10'h0, ib}});
            wr_reg(ias_pkg::OFS_DEST, {26'h0, id});
            wr_reg(ias_pkg::OFS_CMD, {29'h0, op});
            rchk(ias_pkg::OFS_MEM_BASE + {4'h0, id, 2'h0}, {16'h0, dst});
            rchk(ias_pkg::OFS_FLAGS, {28'h0, dst[15], dst == 16'h0, ov, cy});
            rchk(ias_pkg::OFS_INT_STAT, {31'h0, trap});
            rchk(ias_pkg::OFS_MATH_LO, {16'h0, math[15:0]});
            rchk(ias_pkg::OFS_MATH_HI, {16'h0, math[31:16]});
        end
        // overflow raises the trap, then mask, end and clear
        wr_reg(ias_pkg::OFS_SRC_A, 32'h0001_7FFF);
        wr_reg(ias_pkg::OFS_SRC_B, 32'h0001_0001);
        wr_reg(ias_pkg::OFS_CMD, 32'h1);
        wr_reg(ias_pkg::OFS_INT_MASK, 32'h1);
        #1 chk({31'h0, irq}, 32'h1);
        wr_reg(ias_pkg::OFS_INT_MASK, 32'h0);
        #1 chk({31'h0, irq}, 32'h0);
        wr_reg(ias_pkg::OFS_CMD, 32'h4);
        #1 chk({31'h0, major}, 32'h1);
        rchk(ias_pkg::OFS_ERR_CODE, 32'h20);
        wr_reg(ias_pkg::OFS_INT_STAT, 32'h3);
        rchk(ias_pkg::OFS_INT_STAT, 32'h0);
        rchk(ias_pkg::OFS_ERR_CODE, 32'h0);
        wr_reg(ias_pkg::OFS_CMD, 32'h5);
        #1 chk({31'h0, major}, 32'h0);
        wr_reg(ias_pkg::OFS_SRC_B, 32'h0001_FFFF);
        wr_reg(ias_pkg::OFS_CMD, 32'h2);
        wr_reg(ias_pkg::OFS_CMD, 32'h5);
        #1 chk({31'h0, major}, 32'h1);
        rchk(12'h0FC, 32'h0);
        stop_test();
    end
endmodule
bind ias_top ias_asserts ias_asserts_inst (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .IRQ(IRQ), .MAJOR_ERROR(MAJOR_ERROR));
